// file: hw/acmp_edge.sv
// Purpose: edge event detector for the synchronised comparator result
// Assumes: input already on clk
// Notes: reserved mode gives no event
`timescale 1ns/1ps
`default_nettype none
module acmp_edge
   import acmp_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic level,
   input wire acmp_mode_type mode,
   output logic event_pulse
);
   typedef struct packed {
      logic prev;
      logic primed;
   } acmp_edge_state_type;
   acmp_edge_state_type state_ff;
   acmp_edge_state_type nxt_state;

   // selected edge check
   function automatic logic edge_hit(input acmp_mode_type m, input logic p, input logic c);
      case (m)
         ACMP_MODE_TOGGLE: edge_hit = p ^ c;
         ACMP_MODE_FALL: edge_hit = p & ~c;
         ACMP_MODE_RISE: edge_hit = ~p & c;
         default: edge_hit = 1'b0; // RULE_15
      endcase
   endfunction

   // remember last level; no event before first sample
   always_comb
   begin
      nxt_state.prev = level;
      nxt_state.primed = 1'b1;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         state_ff <= '0;
      else
         state_ff <= nxt_state;
   end

   assign event_pulse = state_ff.primed & edge_hit(mode, state_ff.prev, level); // RULE_11
endmodule
`default_nettype wire

// file: hw/acmp_pkg.sv
// Purpose: shared constants and types for the comparator control block
// Assumes: avalon-mm slave with 32-bit data, 8-bit registers in low bits
// Notes: register offsets are byte addresses
package acmp_pkg;
   // register byte offsets
   localparam logic [3:0] ACMP_OFS_CTRL = 4'h0;
   localparam logic [3:0] ACMP_OFS_DIS = 4'h4;
   localparam logic [3:0] ACMP_OFS_PIN = 4'h8;
   localparam logic [3:0] ACMP_OFS_VEC = 4'hC;
   // control/status field positions
   localparam int ACMP_BIT_OFF = 7;
   localparam int ACMP_BIT_REF = 6;
   localparam int ACMP_BIT_RES = 5;
   localparam int ACMP_BIT_FLAG = 4;
   localparam int ACMP_BIT_IEN = 3;
   localparam int ACMP_BIT_CAP = 2;
   localparam int ACMP_BIT_MHI = 1;
   localparam int ACMP_BIT_MLO = 0;
   // pin input disable positions
   localparam int ACMP_BIT_NEG_OFF = 1;
   localparam int ACMP_BIT_POS_OFF = 0;
   // reset values
   localparam logic [7:0] ACMP_RST_CTRL = 8'h00;
   localparam logic [7:0] ACMP_RST_DIS = 8'h00;
   // edge modes
   typedef enum logic [1:0] {
      ACMP_MODE_TOGGLE = 2'h0,
      ACMP_MODE_RESV = 2'h1,
      ACMP_MODE_FALL = 2'h2,
      ACMP_MODE_RISE = 2'h3
   } acmp_mode_type;
   // bus transaction states
   typedef enum logic [1:0] {
      ACMP_BUS_IDLE = 2'h0,
      ACMP_BUS_ACK = 2'h1
   } acmp_bus_state_type;
   // analog front-end control
   typedef struct packed {
      logic power_off;
      logic ref_select;
      logic pos_input_off;
      logic neg_input_off;
   } acmp_analog_ctrl_type;
endpackage

// file: hw/acmp_sync.sv
// Purpose: two-flop synchroniser for one level
// Assumes: input is asynchronous to clk
// Notes: first flop is read only by the second
`timescale 1ns/1ps
`default_nettype none
module acmp_sync
   import acmp_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic d,
   output logic q
);
   typedef struct packed {
      logic meta;
      logic sync;
   } acmp_sync_state_type;
   acmp_sync_state_type state_ff;
   acmp_sync_state_type nxt_state;

   // shift the level through two stages
   always_comb
   begin
      nxt_state.meta = d;
      nxt_state.sync = state_ff.meta;
   end

   // state register
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         state_ff <= '0;
      else
         state_ff <= nxt_state;
   end

   assign q = state_ff.sync;
endmodule
`default_nettype wire

// file: hw/acmp_top.sv
// Purpose: control and status logic around an on-chip voltage comparator
// Assumes: 20 MHz clk, avalon-mm slave, analog compare done outside
// Notes: registers are 8 bits wide in the low byte of each word
//
// What this block does
// RULE_01 - result synchronised, one to two cycles
// RULE_02 - result high when positive above negative
// RULE_03 - power-off bit seven switches comparator off
// RULE_04 - bit six picks reference for positive
// RULE_05 - selected edge sets flag bit four
// RULE_06 - vector entry clears the flag
// RULE_07 - writing one clears flag
// RULE_08 - request needs flag, enable, global enable
// RULE_09 - capture bit routes result to timer
// RULE_10 - capture bit low disconnects timer
// RULE_11 - mode: toggle, falling, rising, reserved
// RULE_12 - software disables irq before power change
// RULE_13 - software disables irq before mode change
// RULE_14 - input-off bits force port bits zero
// RULE_15 - reserved mode never sets flag
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module acmp_top
   import acmp_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // analog comparator core
   input wire logic comparator_raw,
   output logic comparator_power_off,
   output logic reference_select,
   // analog pins digital path
   input wire logic positive_analog_pin,
   input wire logic negative_analog_pin,
   output logic positive_pin_input_off,
   output logic negative_pin_input_off,
   // processor side
   input wire logic global_irq_enable,
   input wire logic irq_vector_ack,
   output logic irq,
   // timer capture front end
   output logic capture_source,
   output logic capture_route_enable
);
   typedef struct packed {
      acmp_bus_state_type bus;
      logic [31:0] rdata;
      logic power_off;
      logic ref_sel;
      logic irq_flag;
      logic irq_en;
      logic cap_en;
      acmp_mode_type mode;
      logic neg_off;
      logic pos_off;
      logic irq;
      logic cap_src;
      logic [1:0] pin_sync1;
      logic [1:0] pin_sync2;
   } acmp_top_state_type;

   acmp_top_state_type state_ff;
   acmp_top_state_type nxt_state;
   logic result_sync;
   logic result_live;
   logic edge_event;
   logic wr_hit;
   logic rd_hit;

   // comparator result into clk domain
   acmp_sync u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .d(comparator_raw),
      .q(result_sync) // RULE_01
   );

   // powered-off comparator reads low; gating sits past the flops
   assign result_live = result_sync & ~state_ff.power_off; // RULE_02 RULE_03

   // edge detection per mode
   acmp_edge u_edge (
      .clk(clk),
      .arst_n(arst_n),
      .level(result_live),
      .mode(state_ff.mode),
      .event_pulse(edge_event) // RULE_05
   );

   // byte lane 0 holds every register
   // writes land in the ack cycle, at the edge the master samples
   assign wr_hit = avs_write && state_ff.bus == ACMP_BUS_ACK && avs_byteenable[0];
   assign rd_hit = avs_read && state_ff.bus == ACMP_BUS_IDLE;

   // read mux for control and status
   function automatic logic [7:0] ctrl_word(input acmp_top_state_type s, input logic res);
      logic [7:0] w;
      w = 8'h00;
      w[ACMP_BIT_OFF] = s.power_off;
      w[ACMP_BIT_REF] = s.ref_sel;
      w[ACMP_BIT_RES] = res;
      w[ACMP_BIT_FLAG] = s.irq_flag;
      w[ACMP_BIT_IEN] = s.irq_en;
      w[ACMP_BIT_CAP] = s.cap_en;
      w[ACMP_BIT_MHI:ACMP_BIT_MLO] = s.mode;
      ctrl_word = w;
   endfunction

   // next state: bus, registers, flag, request
   always_comb
   begin
      nxt_state = state_ff;
      // bus handshake: one wait cycle then ack
      case (state_ff.bus)
         ACMP_BUS_IDLE:
         begin
            if (avs_read || avs_write)
               nxt_state.bus = ACMP_BUS_ACK;
         end
         ACMP_BUS_ACK:
            nxt_state.bus = ACMP_BUS_IDLE;
         default:
            nxt_state.bus = ACMP_BUS_IDLE;
      endcase
      // read data capture, unmapped reads zero
      if (rd_hit)
      begin
         nxt_state.rdata = 32'h0000_0000;
         case (avs_address)
            ACMP_OFS_CTRL: nxt_state.rdata[7:0] = ctrl_word(state_ff, result_live);
            ACMP_OFS_DIS: nxt_state.rdata[1:0] = {state_ff.neg_off, state_ff.pos_off};
            ACMP_OFS_PIN:
               nxt_state.rdata[1:0] = state_ff.pin_sync2 & ~{state_ff.neg_off, state_ff.pos_off}; // RULE_14
            default: nxt_state.rdata = 32'h0000_0000;
         endcase
      end
      // register writes
      if (wr_hit && avs_address == ACMP_OFS_CTRL)
      begin
         nxt_state.power_off = avs_writedata[ACMP_BIT_OFF]; // RULE_03
         nxt_state.ref_sel = avs_writedata[ACMP_BIT_REF]; // RULE_04
         nxt_state.irq_en = avs_writedata[ACMP_BIT_IEN];
         nxt_state.cap_en = avs_writedata[ACMP_BIT_CAP];
         nxt_state.mode = acmp_mode_type'(avs_writedata[ACMP_BIT_MHI:ACMP_BIT_MLO]);
      end
      if (wr_hit && avs_address == ACMP_OFS_DIS)
      begin
         nxt_state.neg_off = avs_writedata[ACMP_BIT_NEG_OFF];
         nxt_state.pos_off = avs_writedata[ACMP_BIT_POS_OFF];
      end
      // flag: write-one or vector clears, event wins
      if (wr_hit && avs_address == ACMP_OFS_CTRL && avs_writedata[ACMP_BIT_FLAG])
         nxt_state.irq_flag = 1'b0; // RULE_07
      if (irq_vector_ack)
         nxt_state.irq_flag = 1'b0; // RULE_06
      if (edge_event)
         nxt_state.irq_flag = 1'b1; // RULE_05
      // level request to the processor
      nxt_state.irq = nxt_state.irq_flag & nxt_state.irq_en & global_irq_enable; // RULE_08
      // capture path gated by route bit
      nxt_state.cap_src = nxt_state.cap_en & result_live; // RULE_09 RULE_10
      // pin inputs: two bare flops, buffer-off gating at the read
      nxt_state.pin_sync1 = {negative_analog_pin, positive_analog_pin};
      nxt_state.pin_sync2 = state_ff.pin_sync1;
   end

   // state register
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_ff <= '0;
         state_ff.bus <= ACMP_BUS_IDLE;
         state_ff.mode <= ACMP_MODE_TOGGLE;
      end
      else
         state_ff <= nxt_state;
   end

   // outputs straight from flops
   assign avs_readdata = state_ff.rdata;
   assign avs_waitrequest = ~(state_ff.bus == ACMP_BUS_ACK);
   assign comparator_power_off = state_ff.power_off; // RULE_03
   assign reference_select = state_ff.ref_sel; // RULE_04
   assign positive_pin_input_off = state_ff.pos_off; // RULE_14
   assign negative_pin_input_off = state_ff.neg_off; // RULE_14
   assign irq = state_ff.irq;
   assign capture_source = state_ff.cap_src; // RULE_09
   assign capture_route_enable = state_ff.cap_en; // RULE_10
endmodule
`default_nettype wire

// file: tb/acmp_checker.sv
// Purpose: port-level checks on the comparator control block
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to every acmp_top instance
`timescale 1ns/1ps
`default_nettype none
module acmp_checker
   import acmp_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic avs_waitrequest,
   input wire logic comparator_raw,
   input wire logic comparator_power_off,
   input wire logic reference_select,
   input wire logic positive_pin_input_off,
   input wire logic negative_pin_input_off,
   input wire logic global_irq_enable,
   input wire logic irq_vector_ack,
   input wire logic irq,
   input wire logic capture_source,
   input wire logic capture_route_enable
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   logic wctl;
   logic wdis;
   // accepted writes at the answer edge
   assign wctl = avs_write && !avs_waitrequest && avs_byteenable[0]
                 && avs_address == ACMP_OFS_CTRL;
   assign wdis = avs_write && !avs_waitrequest && avs_byteenable[0]
                 && avs_address == ACMP_OFS_DIS;
   AST_POWER_OFF: assert property (wctl |=> comparator_power_off == $past(avs_writedata[7]))
      else $error("power off bit not taken");
   AST_REF_SEL: assert property (wctl |=> reference_select == $past(avs_writedata[6]))
      else $error("reference select not taken");
   AST_ROUTE_WR: assert property (wctl |=> capture_route_enable == $past(avs_writedata[2]))
      else $error("capture route not taken");
   AST_PIN_OFF: assert property (wdis |=>
      {negative_pin_input_off, positive_pin_input_off} == $past(avs_writedata[1:0]))
      else $error("input off bits not taken");
   AST_IRQ_GLOBAL: assert property (irq |-> $past(global_irq_enable))
      else $error("irq without global enable");
   AST_IEN_OFF: assert property (wctl && !avs_writedata[3] |=> !irq)
      else $error("irq after enable cleared");
   AST_CAP_OFF: assert property (!capture_route_enable && !$past(capture_route_enable) |-> !capture_source)
      else $error("capture driven while unrouted");
   AST_CAP_FOLLOW: assert property ($stable(comparator_raw)[*4] ##0
      (capture_route_enable && $past(capture_route_enable) && !$past(comparator_power_off)
      && !$past(comparator_power_off, 2)) |-> capture_source == comparator_raw)
      else $error("capture does not follow result");
   AST_VEC_CLR: assert property ($stable(comparator_raw)[*5] ##0 irq_vector_ack
      ##1 $stable(comparator_raw) |=> !irq)
      else $error("vector entry left irq set");
endmodule
bind acmp_top acmp_checker chk (.*);
`default_nettype wire

// file: tb/acmp_partner.sv
// Purpose: behavioural analog comparator facing the block
// Assumes: levels are unsigned codes of pin voltages
// Notes: output held low while unpowered
`timescale 1ns/1ps
`default_nettype none
module acmp_partner
   import acmp_pkg::*;
#(
   parameter logic [7:0] REF_LEVEL = 8'h80
)
(
   input wire logic [7:0] pos_level,
   input wire logic [7:0] neg_level,
   input wire logic reference_select,
   input wire logic comparator_power_off,
   output logic comparator_raw
);
   logic [7:0] plus_in;
   // reference or pin on the plus side
   assign plus_in = reference_select ? REF_LEVEL : pos_level;
   // high when plus exceeds minus
   assign comparator_raw = !comparator_power_off && (plus_in > neg_level);
endmodule
`default_nettype wire

// file: tb/acmp_top_tb.sv
// Purpose: self-checking bench for the comparator control block
// Assumes: 20 MHz clock, bus answers after one wait cycle
// Notes: edge modes from a table, the rest by hand
`timescale 1ns/1ps
`default_nettype none
module acmp_top_tb;
   import acmp_pkg::*;
   typedef struct packed {logic [1:0] mode; logic from; logic to; logic flag;} acmp_row_type;
   acmp_row_type rows [8] = '{5'h03, 5'h05, 5'h12, 5'h15, 5'h1B, 5'h1C, 5'h0A, 5'h0C};
   logic clk = 1'h0;
   logic arst_n = 1'h0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'h0;
   logic avs_write = 1'h0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, comparator_raw, comparator_power_off, reference_select, irq;
   logic positive_pin_input_off, negative_pin_input_off, capture_source, capture_route_enable;
   logic positive_analog_pin = 1'h0;
   logic negative_analog_pin = 1'h0;
   logic global_irq_enable = 1'h0;
   logic irq_vector_ack = 1'h0;
   logic [7:0] pos_level = 8'h10;
   logic [7:0] neg_level = 8'h50;
   logic [7:0] q;
   int fails = 0;
   int checked = 0;
   acmp_top dut (.*);
   acmp_partner model (.*);
   // free-running clock
   always #25 clk = ~clk;
   function automatic logic [7:0] lvl(input logic b);
      return b ? 8'h90 : 8'h10;
   endfunction
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one bus cycle, held until waitrequest is low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'h0) @(posedge clk);
      q = avs_readdata[7:0];
      avs_read <= 1'h0;
      avs_write <= 1'h0;
   endtask
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic conclude();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // watchdog against a hung handshake
   initial
   begin
      #100000;
      fails++;
      conclude();
   end
   // reset, mode table, then hand cases
   initial
   begin
      wt(2);
      arst_n <= 1'h1;
      bus(1'h0, ACMP_OFS_CTRL, 8'h00);
      chk("ctrl reset", q & 8'hDF, ACMP_RST_CTRL);
      bus(1'h0, ACMP_OFS_DIS, 8'h00);
      chk("dis reset", q, ACMP_RST_DIS);
      bus(1'h0, 4'hC, 8'h00);
      chk("unmapped", q, 8'h00);
      foreach (rows[i])
      begin
         pos_level <= lvl(rows[i].from);
         bus(1'h1, ACMP_OFS_CTRL, {6'h00, rows[i].mode});
         wt(6);
         bus(1'h1, ACMP_OFS_CTRL, {6'h04, rows[i].mode});
         pos_level <= lvl(rows[i].to);
         wt(6);
         bus(1'h0, ACMP_OFS_CTRL, 8'h00);
         chk("mode row", q & 8'h30, {2'h0, rows[i].to, rows[i].flag, 4'h0});
      end
      bus(1'h1, ACMP_OFS_CTRL, 8'h13);
      pos_level <= 8'h90;
      wt(6);
      bus(1'h1, ACMP_OFS_CTRL, 8'h0B);
      bus(1'h0, ACMP_OFS_CTRL, 8'h00);
      chk("flag kept", q & 8'h10, 8'h10);
      global_irq_enable <= 1'h1;
      wt(3);
      @(negedge clk);
      chk("irq on", {7'h0, irq}, 8'h01);
      wt(1);
      global_irq_enable <= 1'h0;
      wt(2);
      @(negedge clk);
      chk("irq masked", {7'h0, irq}, 8'h00);
      wt(1);
      global_irq_enable <= 1'h1;
      irq_vector_ack <= 1'h1;
      wt(1);
      irq_vector_ack <= 1'h0;
      wt(3);
      @(negedge clk);
      chk("irq vector", {7'h0, irq}, 8'h00);
      bus(1'h1, ACMP_OFS_CTRL, 8'h00);
      pos_level <= 8'h10;
      bus(1'h1, ACMP_OFS_CTRL, 8'h40);
      wt(4);
      bus(1'h0, ACMP_OFS_CTRL, 8'h00);
      chk("reference", q & 8'h60, 8'h60);
      pos_level <= 8'h90;
      bus(1'h1, ACMP_OFS_CTRL, 8'h80);
      wt(4);
      bus(1'h0, ACMP_OFS_CTRL, 8'h00);
      chk("power off", q & 8'hA0, 8'h80);
      bus(1'h1, ACMP_OFS_CTRL, 8'h04);
      wt(4);
      @(negedge clk);
      chk("cap on", {6'h0, capture_route_enable, capture_source}, 8'h03);
      bus(1'h1, ACMP_OFS_CTRL, 8'h00);
      wt(4);
      @(negedge clk);
      chk("cap off", {6'h0, capture_route_enable, capture_source}, 8'h00);
      bus(1'h1, ACMP_OFS_DIS, 8'h03);
      positive_analog_pin <= 1'h1;
      negative_analog_pin <= 1'h1;
      wt(3);
      bus(1'h0, ACMP_OFS_PIN, 8'h00);
      chk("pins off", q, 8'h00);
      bus(1'h1, ACMP_OFS_DIS, 8'h01);
      wt(3);
      bus(1'h0, ACMP_OFS_PIN, 8'h00);
      chk("pin neg", q, 8'h02);
      // mid-run reset with flag, enable and route set
      pos_level <= 8'h10;
      bus(1'h1, ACMP_OFS_CTRL, 8'h0C);
      wt(4);
      arst_n <= 1'h0;
      wt(2);
      arst_n <= 1'h1;
      bus(1'h0, ACMP_OFS_CTRL, 8'h00);
      chk("ctrl re-reset", q & 8'hDF, ACMP_RST_CTRL);
      bus(1'h0, ACMP_OFS_DIS, 8'h00);
      chk("dis re-reset", q, ACMP_RST_DIS);
      conclude();
   end
endmodule
`default_nettype wire
